// File: core/dac_ctrl_pkg.sv
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
// Summary of operation
// - Clear low zeroes all four registers
// - Sixteen-bit word per frame, MSB first
// - Bit 15 picks channel A or B
// - Bit 14 picks gain, default zero
// - Bits 11..0 data, low bits ignored
// - Codes are straight binary
// - Frame low; sample on falling clock edges
// - Ignore clocks after sixteen until reframe
// - Complete word loads selected input register
// - Early frame rise abandons partial word
// - Load low makes DAC registers transparent
// - DAC register updates only after input write
// - Serial inputs disabled until next frame
// - Bits 13..12 select power mode
// - Power-down keeps register contents
// - Hardware power-down forces high impedance
// - Power-on zeroes registers, normal mode
package dac_ctrl_pkg;
    localparam int WORD_BITS = 16;
    localparam int CNT_BITS = 5;
    localparam int CH_SEL_POS = 15;
    localparam int GAIN_POS = 14;
    localparam int MODE_HI_POS = 13;
    localparam int MODE_LO_POS = 12;
    localparam int DATA_MSB = 11;
    localparam int DATA_BITS_MAX = 12;
    localparam logic [CNT_BITS-1:0] WORD_COUNT = 5'h10;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PD_1K = 2'h1;
    localparam logic [1:0] MODE_PD_100K = 2'h2;
    localparam logic [1:0] MODE_PD_HIZ = 2'h3;
    localparam logic [15:0] REG_RESET = 16'h0000;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_SHIFT = 2'b01,
        RX_DONE = 2'b11
    } rx_state_t;
endpackage : dac_ctrl_pkg

// File: core/dac_channel.sv
// One channel: input register and DAC register with update flag
module dac_channel
    import dac_ctrl_pkg::*;
#(
    parameter int RES = 12
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Controls
    input wire logic i_clear,
    input wire logic i_write,
    input wire logic [RES+2:0] i_word,
    input wire logic i_load,
    // State
    output logic [RES+2:0] o_dac_word
);
    logic [RES+2:0] in_ff, nxt_in;
    logic [RES+2:0] dac_ff, nxt_dac;
    logic fresh_ff, nxt_fresh;

    always_comb begin
        nxt_in = in_ff;
        nxt_dac = dac_ff;
        nxt_fresh = fresh_ff;
        if (i_clear) begin
            nxt_in = '0;
            nxt_dac = '0;
            nxt_fresh = 1'b0;
        end else begin
            if (i_load && fresh_ff) begin
                nxt_dac = in_ff;
                nxt_fresh = 1'b0;
            end
            if (i_write) begin
                nxt_in = i_word;
                nxt_fresh = 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            in_ff <= '0;
            dac_ff <= '0;
            fresh_ff <= 1'b0;
        end else begin
            in_ff <= nxt_in;
            dac_ff <= nxt_dac;
            fresh_ff <= nxt_fresh;
        end
    end

    assign o_dac_word = dac_ff;
endmodule : dac_channel

// File: core/dual_dac_serial_control.sv
module dual_dac_serial_control
    import dac_ctrl_pkg::*;
#(
    parameter int RES = 12
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Serial link pins
    input wire logic i_frame_n,
    input wire logic i_sclk,
    input wire logic i_sdata,
    // Control pins
    input wire logic i_async_zero_n,
    input wire logic i_load_outputs_n,
    input wire logic i_hw_powerdown_n,
    // Channel A state
    output logic [RES-1:0] o_code_a,
    output logic o_gain_a,
    output logic [1:0] o_mode_a,
    // Channel B state
    output logic [RES-1:0] o_code_b,
    output logic o_gain_b,
    output logic [1:0] o_mode_b,
    // Serial input buffers enabled
    output logic o_rx_active
);
    //------------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------------
    logic [5:0] sync1_ff, sync2_ff;
    logic sclk_prev_ff, frame_prev_ff;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_ff <= 6'h3f;
            sync2_ff <= 6'h3f;
            sclk_prev_ff <= 1'b1;
            frame_prev_ff <= 1'b1;
        end else begin
            sync1_ff <= {i_frame_n, i_sclk, i_sdata, i_async_zero_n,
                         i_load_outputs_n, i_hw_powerdown_n};
            sync2_ff <= sync1_ff;
            sclk_prev_ff <= sync2_ff[4];
            frame_prev_ff <= sync2_ff[5];
        end
    end

    logic frame_s, sclk_s, sdata_s, zero_s, load_s, pd_s;
    assign {frame_s, sclk_s, sdata_s, zero_s, load_s, pd_s} = sync2_ff;

    logic sclk_fall, frame_fall, clear;
    assign sclk_fall = sclk_prev_ff & ~sclk_s;
    assign frame_fall = frame_prev_ff & ~frame_s;
    assign clear = ~zero_s;

    //------------------------------------------------------------------
    // Serial receiver
    //------------------------------------------------------------------
    rx_state_t state_ff, nxt_state;
    logic [WORD_BITS-1:0] shift_ff, nxt_shift;
    logic [CNT_BITS-1:0] cnt_ff, nxt_cnt;
    logic done_ff, nxt_done;

    always_comb begin
        nxt_state = state_ff;
        nxt_shift = shift_ff;
        nxt_cnt = cnt_ff;
        nxt_done = 1'b0;
        unique case (state_ff)
            RX_IDLE: begin
                if (frame_fall) begin
                    nxt_state = RX_SHIFT;
                    nxt_cnt = '0;
                end
            end
            RX_SHIFT: begin
                if (frame_s) begin
                    nxt_state = RX_IDLE;
                end else if (sclk_fall) begin
                    nxt_shift = {shift_ff[WORD_BITS-2:0], sdata_s};
                    nxt_cnt = cnt_ff + 5'h01;
                    if (cnt_ff + 5'h01 == WORD_COUNT) begin
                        nxt_state = RX_DONE;
                        nxt_done = 1'b1;
                    end
                end
            end
            RX_DONE: begin
                if (frame_s) begin
                    nxt_state = RX_IDLE;
                end
            end
            default: nxt_state = RX_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= RX_IDLE;
            shift_ff <= '0;
            cnt_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            shift_ff <= nxt_shift;
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    //------------------------------------------------------------------
    // Word decode
    //------------------------------------------------------------------
    logic [RES+2:0] word_fields;
    logic sel_b;
    // Gain, mode, then top RES data bits; lower bits dropped
    assign word_fields = {shift_ff[GAIN_POS], shift_ff[MODE_HI_POS],
                          shift_ff[MODE_LO_POS],
                          shift_ff[DATA_MSB -: RES]};
    assign sel_b = shift_ff[CH_SEL_POS];

    //------------------------------------------------------------------
    // Channels
    //------------------------------------------------------------------
    logic [RES+2:0] dac_a, dac_b;

    dac_channel #(.RES(RES)) u_ch_a (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_clear(clear),
        .i_write(done_ff & ~sel_b),
        .i_word(word_fields),
        .i_load(~load_s),
        .o_dac_word(dac_a)
    );

    dac_channel #(.RES(RES)) u_ch_b (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_clear(clear),
        .i_write(done_ff & sel_b),
        .i_word(word_fields),
        .i_load(~load_s),
        .o_dac_word(dac_b)
    );

    //------------------------------------------------------------------
    // Output registers
    //------------------------------------------------------------------
    logic [RES-1:0] code_a_ff, code_b_ff, nxt_code_a, nxt_code_b;
    logic gain_a_ff, gain_b_ff, nxt_gain_a, nxt_gain_b;
    logic [1:0] mode_a_ff, mode_b_ff, nxt_mode_a, nxt_mode_b;
    logic active_ff, nxt_active;

    always_comb begin
        // Codes pass as straight binary; mode bits never touch codes
        nxt_code_a = dac_a[RES-1:0];
        nxt_code_b = dac_b[RES-1:0];
        nxt_gain_a = dac_a[RES+2];
        nxt_gain_b = dac_b[RES+2];
        nxt_mode_a = pd_s ? dac_a[RES+1:RES] : MODE_PD_HIZ;
        nxt_mode_b = pd_s ? dac_b[RES+1:RES] : MODE_PD_HIZ;
        nxt_active = (nxt_state == RX_SHIFT);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            code_a_ff <= '0;
            code_b_ff <= '0;
            gain_a_ff <= 1'b0;
            gain_b_ff <= 1'b0;
            mode_a_ff <= MODE_NORMAL;
            mode_b_ff <= MODE_NORMAL;
            active_ff <= 1'b0;
        end else begin
            code_a_ff <= nxt_code_a;
            code_b_ff <= nxt_code_b;
            gain_a_ff <= nxt_gain_a;
            gain_b_ff <= nxt_gain_b;
            mode_a_ff <= nxt_mode_a;
            mode_b_ff <= nxt_mode_b;
            active_ff <= nxt_active;
        end
    end

    assign o_code_a = code_a_ff;
    assign o_code_b = code_b_ff;
    assign o_gain_a = gain_a_ff;
    assign o_gain_b = gain_b_ff;
    assign o_mode_a = mode_a_ff;
    assign o_mode_b = mode_b_ff;
    assign o_rx_active = active_ff;
endmodule : dual_dac_serial_control

// File: test/dual_dac_serial_control_assertions.sv
module dac_ctrl_chk
    import dac_ctrl_pkg::*;
#(
    parameter int RES = 12
) (
    // Clock, reset, pins
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_frame_n,
    input wire logic i_async_zero_n,
    input wire logic i_load_outputs_n,
    input wire logic i_hw_powerdown_n,
    // Outputs
    input wire logic [RES-1:0] o_code_a,
    input wire logic o_gain_a,
    input wire logic [1:0] o_mode_a,
    input wire logic [RES-1:0] o_code_b,
    input wire logic o_gain_b,
    input wire logic [1:0] o_mode_b,
    input wire logic o_rx_active
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_clr;
        !i_async_zero_n [*6];
    endsequence
    sequence s_quiet;
        (i_load_outputs_n && i_async_zero_n && i_hw_powerdown_n) [*8];
    endsequence
    property p_clr_code;
        s_clr |-> o_code_a == '0 && o_code_b == '0;
    endproperty
    a_clr_code: assert property (p_clr_code) else $error("clear code");
    property p_clr_ctl;
        s_clr |-> !o_gain_a && !o_gain_b;
    endproperty
    a_clr_ctl: assert property (p_clr_ctl) else $error("clear gain");
    property p_hold_code;
        s_quiet |=> $stable(o_code_a) && $stable(o_code_b);
    endproperty
    a_hold_code: assert property (p_hold_code) else $error("code moved");
    property p_hold_ctl;
        s_quiet |=> $stable({o_gain_a, o_mode_a, o_gain_b, o_mode_b});
    endproperty
    a_hold_ctl: assert property (p_hold_ctl) else $error("ctl moved");
    property p_pd;
        !i_hw_powerdown_n [*5] |-> o_mode_a == MODE_PD_HIZ
            && o_mode_b == MODE_PD_HIZ;
    endproperty
    a_pd: assert property (p_pd) else $error("pd not hi-z");
    property p_rx_idle;
        i_frame_n [*6] |-> !o_rx_active;
    endproperty
    a_rx_idle: assert property (p_rx_idle) else $error("rx on");
    property p_rx_start;
        $rose(o_rx_active) |-> !i_frame_n;
    endproperty
    a_rx_start: assert property (p_rx_start) else $error("rx early");
    property p_rx_abort;
        $rose(i_frame_n) |-> ##[1:6] !o_rx_active;
    endproperty
    a_rx_abort: assert property (p_rx_abort) else $error("rx stuck");
endmodule : dac_ctrl_chk

bind dual_dac_serial_control dac_ctrl_chk #(.RES(RES)) chk_u (.*);

// File: test/dac_host_model.sv
module dac_host_model (
    output logic o_frame_n,
    output logic o_sclk,
    output logic o_sdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_frame_n = 1'b1;
        o_sclk = 1'b1;
        o_sdata = 1'b0;
    end
    // ----
    // One frame of n clocks, 200 ns period
    // ----
    task automatic send(input logic [15:0] w, input int n);
        o_frame_n = 1'b0;
        #100;
        for (int i = 0; i < n; i++) begin
            o_sdata = (i < 16) ? w[15-i] : ~o_sdata;
            #100 o_sclk = 1'b0;
            #100 o_sclk = 1'b1;
        end
        #100 o_frame_n = 1'b1;
        o_sdata = ~o_sdata;
        #100;
    endtask : send
endmodule : dac_host_model

// File: test/dual_dac_serial_control_tb.sv
module dual_dac_serial_control_tb;
    import dac_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic zero_n = 1'b1;
    logic load_n = 1'b0;
    logic pd_n = 1'b1;
    logic frame_n, sclk, sdata, rx, gain_a, gain_b;
    logic [11:0] code_a, code_b;
    logic [1:0] mode_a, mode_b;
    int err_count = 0;
    int samples_checked = 0;
    typedef struct packed {logic [15:0] w; logic [14:0] e;} row_t;
    row_t rows [5] = '{'{16'h0abc, 15'h0abc}, '{16'hd123, 15'h5123},
        '{16'h2fff, 15'h2fff}, '{16'hb000, 15'h3000},
        '{16'h4001, 15'h4001}};
    always #12.5 clk = ~clk;
    dac_host_model host_u (.o_frame_n(frame_n), .o_sclk(sclk),
        .o_sdata(sdata));
    dual_dac_serial_control dut_u (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_frame_n(frame_n), .i_sclk(sclk), .i_sdata(sdata),
        .i_async_zero_n(zero_n), .i_load_outputs_n(load_n),
        .i_hw_powerdown_n(pd_n), .o_code_a(code_a), .o_gain_a(gain_a),
        .o_mode_a(mode_a), .o_code_b(code_b), .o_gain_b(gain_b),
        .o_mode_b(mode_b), .o_rx_active(rx));
    // ----
    // Helpers
    // ----
    task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [14:0] ch(input logic b);
        return b ? {gain_b, mode_b, code_b} : {gain_a, mode_a, code_a};
    endfunction : ch
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    task automatic close_out;
        $display("checks=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out
    initial begin
        #500_000;
        err_count++;
        close_out();
    end
    initial begin
        idle(5);
        rst_n = 1'b1;
        idle(4);
        foreach (rows[i]) begin
            host_u.send(rows[i].w, 16);
            idle(10);
            chk(ch(rows[i].w[15]), rows[i].e);
        end
        host_u.send(16'h0555, 10);
        idle(10);
        chk(ch(1'b0), 15'h4001);
        host_u.send(16'h8fa5, 20);
        idle(10);
        chk(ch(1'b1), 15'h0fa5);
        load_n = 1'b1;
        host_u.send(16'h07e1, 16);
        idle(10);
        chk(ch(1'b0), 15'h4001);
        load_n = 1'b0;
        idle(10);
        chk(ch(1'b0), 15'h07e1);
        pd_n = 1'b0;
        idle(8);
        chk({11'h0, mode_a, mode_b}, 15'h000f);
        pd_n = 1'b1;
        idle(8);
        chk(ch(1'b0), 15'h07e1);
        zero_n = 1'b0;
        idle(8);
        chk(ch(1'b0) | ch(1'b1), 15'h0000);
        zero_n = 1'b1;
        host_u.send(16'h0123, 16);
        idle(10);
        rst_n = 1'b0;
        idle(2);
        chk(ch(1'b0), 15'h0000);
        rst_n = 1'b1;
        idle(4);
        close_out();
    end
endmodule : dual_dac_serial_control_tb
